// ===== rtl/channel_clock_divider.v
// programmable channel clock divider with sync, force, bypass and phase offset
`timescale 1ns/1ps
`default_nettype none
`include "channel_clock_divider_consts.vh"

module channel_clock_divider (
  // clock and reset
  input  wire                 sys_clk,
  input  wire                 rst_n,
  // register access port
  input  wire                 reg_wr,
  input  wire [`ADDR_W-1:0]   reg_addr,
  input  wire [`DATA_W-1:0]   reg_wdata,
  output reg  [`DATA_W-1:0]   reg_rdata_ff,
  // chip-level sync, active low, asynchronous pin
  input  wire                 sync_n,
  // output driver polarity
  input  wire                 out_invert,
  // divider outputs
  output reg                  clk_out_ff,
  output reg                  div_active_ff,
  output reg                  dcc_enable_ff
);

  ////////////////////////////////////////////////////////////////////////////
  // register address decode, shared by the write and read paths
  localparam SEL_NONE  = 2'b00;
  localparam SEL_PHASE = 2'b01;
  localparam SEL_CTRL  = 2'b10;
  localparam SEL_DCC   = 2'b11;

  function [1:0] reg_sel;
    input [`ADDR_W-1:0] addr;
    begin
      case (addr)
        `ADDR_PHASE_LEN: reg_sel = SEL_PHASE;
        `ADDR_CONTROL:   reg_sel = SEL_CTRL;
        `ADDR_DCC:       reg_sel = SEL_DCC;
        default:         reg_sel = SEL_NONE;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers
  reg [`DATA_W-1:0] phase_len_ff;
  reg [`DATA_W-1:0] control_ff;
  reg               dcc_dis_ff;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_len_ff <= `PHASE_LEN_RESET;
      control_ff   <= `CONTROL_RESET;
      dcc_dis_ff   <= `DCC_RESET;
    end else if (reg_wr) begin
      case (reg_sel(reg_addr))
        SEL_PHASE: begin
          phase_len_ff <= reg_wdata;
        end
        SEL_CTRL: begin
          control_ff <= reg_wdata;
        end
        SEL_DCC: begin
          dcc_dis_ff <= reg_wdata[`DCC_DIS_BIT];
        end
        // unmapped addresses are dropped silently
        default: begin
        end
      endcase
    end
  end

  // read data is registered: it answers the address of one cycle earlier
  reg [`DATA_W-1:0] nxt_reg_rdata;
  always @* begin
    case (reg_sel(reg_addr))
      SEL_PHASE: nxt_reg_rdata = phase_len_ff;
      SEL_CTRL:  nxt_reg_rdata = control_ff;
      SEL_DCC:   nxt_reg_rdata = {{(`DATA_W-1){1'b0}}, dcc_dis_ff};
      default:   nxt_reg_rdata = `READ_ZERO;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // field views of the two divider registers
  wire [3:0] low_len    = phase_len_ff[`LOW_MSB:`LOW_LSB];
  wire [3:0] high_len   = phase_len_ff[`HIGH_MSB:`HIGH_LSB];
  wire       bypass     = control_ff[`BYPASS_BIT];
  wire       ignore_syn = control_ff[`IGNORE_SYNC_BIT];
  wire       force_out  = control_ff[`FORCE_BIT];
  wire       start_high = control_ff[`START_HIGH_BIT];
  wire [3:0] offset     = control_ff[`OFFSET_MSB:`OFFSET_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // sync pin synchroniser
  // both flops preset to idle so leaving reset never looks like a sync pulse
  reg sync_meta_ff;
  reg sync_ff;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_meta_ff <= `SYNC_IDLE;
      sync_ff      <= `SYNC_IDLE;
    end else begin
      sync_meta_ff <= sync_n;
      sync_ff      <= sync_meta_ff;
    end
  end

  // software is expected to set ignore-sync with force; force still wins here
  wire sync_hold = !sync_ff && !ignore_syn;

  ////////////////////////////////////////////////////////////////////////////
  // divider state machine
  // hold parks the counters, delay spends the phase offset, run alternates levels
  localparam ST_HOLD  = 2'b00;
  localparam ST_DELAY = 2'b01;
  localparam ST_RUN   = 2'b10;

  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [3:0] cnt_ff;
  reg [3:0] nxt_cnt;
  reg       level_ff;
  reg       nxt_level;
  reg       bp_tgl_ff;

  always @* begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_level = level_ff;
    if (bypass) begin
      // divider powered down: counters parked for a clean restart
      nxt_state = ST_HOLD;
      nxt_cnt   = `CNT_ZERO;
      nxt_level = start_high;
    end else if (sync_hold) begin
      // sync outranks a running phase but never bypass
      nxt_state = ST_HOLD;
      nxt_cnt   = `CNT_ZERO;
      nxt_level = start_high;
    end else begin
      case (state_ff)
        ST_HOLD: begin
          nxt_level = start_high;
          nxt_cnt   = `CNT_ZERO;
          if (offset == `CNT_ZERO) begin
            nxt_state = ST_RUN;
          end else begin
            nxt_state = ST_DELAY;
            nxt_cnt   = `CNT_ONE;
          end
        end
        ST_DELAY: begin
          if (cnt_ff >= offset) begin
            nxt_state = ST_RUN;
            nxt_cnt   = `CNT_ZERO;
          end else begin
            nxt_cnt = cnt_ff + `CNT_ONE;
          end
        end
        ST_RUN: begin
          // phase ends after field plus one input cycles
          if (cnt_ff >= (level_ff ? high_len : low_len)) begin
            nxt_level = !level_ff;
            nxt_cnt   = `CNT_ZERO;
          end else begin
            nxt_cnt = cnt_ff + `CNT_ONE;
          end
        end
        default: begin
          nxt_state = ST_HOLD;
          nxt_cnt   = `CNT_ZERO;
          nxt_level = start_high;
        end
      endcase
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff  <= ST_HOLD;
      cnt_ff    <= `CNT_ZERO;
      level_ff  <= `LEVEL_RESET;
      bp_tgl_ff <= `LEVEL_RESET;
    end else begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      level_ff  <= nxt_level;
      // bypass stands for the input clock: one level change per rising input edge
      bp_tgl_ff <= bypass ? !bp_tgl_ff : `LEVEL_RESET;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output select
  // limitation: a flop can show the bypassed input clock only at half its rate
  reg nxt_div;
  always @* begin
    if (bypass) begin
      nxt_div = !bp_tgl_ff;
    end else if (force_out) begin
      nxt_div = start_high;
    end else begin
      nxt_div = nxt_level;
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_out_ff    <= `LEVEL_RESET;
      div_active_ff <= 1'b0;
      dcc_enable_ff <= `DCC_EN_RESET;
      reg_rdata_ff  <= `READ_ZERO;
    end else begin
      // inversion comes last so it still reaches the bypassed clock
      clk_out_ff    <= nxt_div ^ out_invert;
      div_active_ff <= !bypass && (nxt_state == ST_RUN);
      dcc_enable_ff <= !dcc_dis_ff;
      reg_rdata_ff  <= nxt_reg_rdata;
    end
  end

endmodule
`default_nettype wire

// ===== rtl/channel_clock_divider_consts.vh
// register map, field positions and reset values of the channel clock divider
// How it works
// - low field plus one gives the number of input cycles the output stays low; resets 0x3
// - high field plus one gives the number of input cycles the output stays high; resets 0x3
// - bypass bit powers the divider down and passes the input clock through at half its rate
// - ignore-sync clear obeys the chip sync signal; set disregards it entirely
// - force bit holds the output static at the start-level bit's value
// - force has no effect in bypass; polarity inversion still applies there
// - start-level bit picks whether the divided clock begins low or high
// - four-bit phase offset in the control register low nibble; resets 0x0
// - duty-cycle correction on when its disable bit is 0, off when 1
`ifndef CHANNEL_CLOCK_DIVIDER_CONSTS_VH
`define CHANNEL_CLOCK_DIVIDER_CONSTS_VH

`define ADDR_W            10
`define DATA_W            8
`define ADDR_PHASE_LEN    10'h193
`define ADDR_CONTROL      10'h194
`define ADDR_DCC          10'h195

`define PHASE_LEN_RESET   8'h33
`define CONTROL_RESET     8'h00
`define DCC_RESET         1'b0
`define READ_ZERO         8'h00
`define SYNC_IDLE         1'b1
`define LEVEL_RESET       1'b0
`define DCC_EN_RESET      1'b1

`define LOW_MSB           7
`define LOW_LSB           4
`define HIGH_MSB          3
`define HIGH_LSB          0
`define BYPASS_BIT        7
`define IGNORE_SYNC_BIT   6
`define FORCE_BIT         5
`define START_HIGH_BIT    4
`define OFFSET_MSB        3
`define OFFSET_LSB        0
`define DCC_DIS_BIT       0

`define CNT_ZERO          4'h0
`define CNT_ONE           4'h1

`endif

// ===== sim/channel_clock_divider_checker.sv
// port assertions for the channel clock divider
`timescale 1ns/1ps
`default_nettype none
module channel_clock_divider_checker (
  // observed design ports
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       reg_wr,
  input wire logic [9:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_ff,
  input wire logic       sync_n,
  input wire logic       out_invert,
  input wire logic       clk_out_ff,
  input wire logic       div_active_ff,
  input wire logic       dcc_enable_ff
);
  logic [7:0] ph_ff, ctl_ff;
  logic [4:0] cnt_ff;
  logic       lvl_ff, ok_ff;
  wire        chg = clk_out_ff != lvl_ff;
  // a level is timed only if it began at a real edge and ran undisturbed
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) {ph_ff, ctl_ff, cnt_ff, lvl_ff, ok_ff} <= {8'h33, 8'h00, 7'h00};
    else begin
      if (reg_wr && reg_addr == 10'h193) ph_ff <= reg_wdata;
      if (reg_wr && reg_addr == 10'h194) ctl_ff <= reg_wdata;
      lvl_ff <= clk_out_ff;
      cnt_ff <= chg ? 5'h01 : cnt_ff + 5'h01;
      ok_ff  <= (chg || ok_ff) && div_active_ff && !reg_wr && !out_invert && !ctl_ff[5];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_phase_read: assert property (reg_addr == 10'h193 |=> reg_rdata_ff == $past(ph_ff))
    else $error("phase read");
  a_ctrl_read: assert property (reg_addr == 10'h194 |=> reg_rdata_ff == $past(ctl_ff))
    else $error("control read");
  a_low_len: assert property (chg && ok_ff && div_active_ff && !lvl_ff |-> cnt_ff == ph_ff[7:4] + 5'h01)
    else $error("low length");
  a_high_len: assert property (chg && ok_ff && div_active_ff && lvl_ff |-> cnt_ff == ph_ff[3:0] + 5'h01)
    else $error("high length");
  a_bypass_pass: assert property ($past(ctl_ff[7], 2) && $past(ctl_ff[7]) && !$past(out_invert)
    && !$past(out_invert, 2) |-> clk_out_ff != $past(clk_out_ff)) else $error("bypass");
  a_force_level: assert property ($past(ctl_ff[5]) && !$past(ctl_ff[7])
    |-> clk_out_ff == ($past(ctl_ff[4]) ^ $past(out_invert))) else $error("force level");
  a_sync_hold: assert property ((!sync_n && ctl_ff[7:5] == 3'b000 && !out_invert && $stable(ctl_ff)) [*6]
    |-> clk_out_ff == ctl_ff[4] && !div_active_ff) else $error("sync hold");
  a_dcc_track: assert property (reg_wr && reg_addr == 10'h195 ##1 !(reg_wr && reg_addr == 10'h195) [*2]
    |-> dcc_enable_ff == !$past(reg_wdata[0], 2)) else $error("dcc state");
endmodule
bind channel_clock_divider channel_clock_divider_checker u_chk (.*);
`default_nettype wire

// ===== sim/testbench.sv
// bench for the channel clock divider
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       sys_clk = 0, rst_n = 0, reg_wr = 0, sync_n = 1, out_invert = 0;
  logic [9:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0;
  wire  [7:0] reg_rdata_ff;
  wire        clk_out_ff, div_active_ff, dcc_enable_ff;
  logic       v;
  int         failures = 0, total_checks = 0, cyc = 0, t0, t5;
  always #10 sys_clk = ~sys_clk;
  channel_clock_divider dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .sync_n(sync_n),
    .out_invert(out_invert), .clk_out_ff(clk_out_ff),
    .div_active_ff(div_active_ff), .dcc_enable_ff(dcc_enable_ff));
  always @(posedge sys_clk) if (++cyc == 3000) print_verdict(1);
  task chk(input string n, input logic [7:0] e, g);
    total_checks++;
    failures += (g !== e);
    if (g !== e) $display("ERROR %s expected %h seen %h", n, e, g);
  endtask
  task wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task wr(input logic [9:0] a, input logic [7:0] d);
    wt(1);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    wt(1);
    reg_wr = 0;
  endtask
  // hold sync long enough to cross the synchroniser, then time the first rise
  task run(input logic [3:0] off, output int t);
    wr(10'h194, {4'h0, off});
    sync_n = 0;
    wt(8);
    sync_n = 1;
    for (t = 0; t < 99 && clk_out_ff !== 1'b1; t++) wt(1);
  endtask
  task t_regs;
    wr(10'h1FF, 8'h55);
    chk("unmapped", 8'h00, reg_rdata_ff);
    wr(10'h195, 8'hFF);
    wt(1);
    chk("dcc reg", 8'h01, reg_rdata_ff);
    chk("dcc", 8'h00, {7'h0, dcc_enable_ff});
    $display("register test done");
  endtask
  task t_offset;
    wr(10'h193, 8'h21);
    run(4'h0, t0);
    wt(30);
    run(4'h5, t5);
    chk("offset", 8'h05, 8'(t5 - t0));
    wr(10'h194, 8'h40);
    sync_n = 0;
    wt(8);
    chk("ignore sync", 8'h01, {7'h0, div_active_ff});
    sync_n = 1;
    $display("offset test done");
  endtask
  task t_force;
    wr(10'h194, 8'h70);
    wt(3);
    chk("forced", 8'h01, {7'h0, clk_out_ff});
    out_invert = 1;
    wt(3);
    out_invert = 0;
    wr(10'h194, 8'hF0);
    wt(2);
    v = clk_out_ff;
    wt(1);
    chk("bypass toggle", {7'h0, !v}, {7'h0, clk_out_ff});
    v = clk_out_ff;
    out_invert = 1;
    wt(1);
    chk("bypass invert", {7'h0, v}, {7'h0, clk_out_ff});
    out_invert = 0;
    wt(8);
    $display("force and bypass test done");
  endtask
  task print_verdict(input int f);
    failures += f;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    wt(12);
    rst_n = 1;
    t_regs;
    t_offset;
    t_force;
    print_verdict(0);
  end
endmodule
`default_nettype wire
